/* File: rtl/asc_ctrl.sv */
// asc_ctrl: host-side controller driving an asynchronous 32768 x 8
// static memory over select, write strobe, output gate and a shared bus.
// assumes user requests and memory data input are synchronous to clk.
//
// How it works
// - writing happens only while select and strobe overlap low.
// - controller never drives the bus while memory may drive it.
// - reads spaced and sampled no sooner than the access time.
// - write strobe low long enough; writes spaced by cycle time.
// - address stable before the write and well before strobe rises.
// - select held low long enough before the write ends.
// - write data set up before the ending edge and held past it.
// - address held steady through the write-ending edge.
// - memory deselected before the supply falls for power-down.
// - after power-down, stay deselected one read cycle before access.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        ce,
   input  wire logic                        req_valid,
   input  wire logic                        req_write,
   input  wire logic [asc_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic [asc_pkg::DATA_W-1:0]  req_wdata,
   output logic                             req_ready,
   output logic                             resp_valid,
   output logic [asc_pkg::DATA_W-1:0]       resp_rdata,
   input  wire logic                        pd_req,
   output logic                             pd_ack,
   output logic [asc_pkg::ADDR_W-1:0]       sram_addr,
   output logic                             sram_cs_n,
   output logic                             sram_we_n,
   output logic                             sram_oe_n,
   output logic [asc_pkg::DATA_W-1:0]       sram_dq_o,
   output logic                             sram_dq_oe,
   input  wire logic [asc_pkg::DATA_W-1:0]  sram_dq_i
);
   import asc_pkg::*;

   asc_state_e       state_q;
   asc_state_e       state_d;
   logic             tmr_load;
   logic [CNT_W-1:0] tmr_val;
   logic             tmr_done;
   logic             take;

   asc_timer u_timer (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   // no new request while power-down is wanted
   assign req_ready = (state_q == ASC_IDLE) && !pd_req;
   assign take = req_valid && req_ready;

   always_comb begin
      state_d = state_q;
      tmr_load = 1'b0;
      tmr_val = '0;
      case (state_q)
         ASC_RECOV: begin
            if (tmr_done) begin
               state_d = ASC_IDLE;
            end
         end
         ASC_IDLE: begin
            if (pd_req) begin
               state_d = ASC_PWRDN;
            end else if (take && req_write) begin
               state_d = ASC_WR_SETUP;
            end else if (take) begin
               state_d = ASC_RD_WAIT;
               tmr_load = 1'b1;
               tmr_val = READ_LOAD;
            end
         end
         ASC_RD_WAIT: begin
            if (tmr_done) begin
               state_d = ASC_TURN;
               tmr_load = 1'b1;
               tmr_val = TURN_LOAD;
            end
         end
         ASC_WR_SETUP: begin
            state_d = ASC_WR_PULSE;
            tmr_load = 1'b1;
            tmr_val = PULSE_LOAD;
         end
         ASC_WR_PULSE: begin
            if (tmr_done) begin
               state_d = ASC_WR_END;
            end
         end
         ASC_WR_END: begin
            state_d = ASC_IDLE;
         end
         ASC_TURN: begin
            if (tmr_done) begin
               state_d = ASC_IDLE;
            end
         end
         ASC_PWRDN: begin
            if (!pd_req) begin
               state_d = ASC_RECOV;
               tmr_load = 1'b1;
               tmr_val = RECOV_LOAD;
            end
         end
         default: begin
            state_d = ASC_RECOV;
         end
      endcase
   end

   // reset starts in recovery: supply may just have come up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ASC_RECOV;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   // select and gate: select stays high outside accesses for standby
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sram_cs_n <= 1'b1;
         sram_oe_n <= 1'b1;
      end else if (ce) begin
         case (state_d)
            ASC_RD_WAIT: begin
               sram_cs_n <= 1'b0;
               sram_oe_n <= 1'b0;
            end
            ASC_WR_SETUP, ASC_WR_PULSE: begin
               sram_cs_n <= 1'b0;
               sram_oe_n <= 1'b1;
            end
            default: begin
               sram_cs_n <= 1'b1;
               sram_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // strobe falls one cycle after select, rises with select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sram_we_n <= 1'b1;
      end else if (ce) begin
         sram_we_n <= (state_d != ASC_WR_PULSE);
      end
   end

   // address and write data latched once and held for the whole cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sram_addr <= ADDR_RST;
         sram_dq_o <= DATA_RST;
      end else if (ce && take) begin
         sram_addr <= req_addr;
         sram_dq_o <= req_wdata;
      end
   end

   // drive the bus only with gate high; held through the end cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sram_dq_oe <= 1'b0;
      end else if (ce) begin
         sram_dq_oe <= (state_d == ASC_WR_SETUP) ||
                       (state_d == ASC_WR_PULSE) ||
                       (state_d == ASC_WR_END);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid <= 1'b0;
         resp_rdata <= DATA_RST;
      end else if (ce) begin
         resp_valid <= 1'b0;
         if (state_q == ASC_RD_WAIT && tmr_done) begin
            resp_valid <= 1'b1;
            resp_rdata <= sram_dq_i;
         end else if (state_q == ASC_WR_END) begin
            resp_valid <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pd_ack <= 1'b0;
      end else if (ce) begin
         pd_ack <= (state_d == ASC_PWRDN);
      end
   end
endmodule
`default_nettype wire

/* File: pkg/asc_pkg.sv */
// asc_pkg: constants for the host-side controller of an asynchronous
// 32768 x 8 static memory with a shared byte bus.
// assumes a 10 MHz system clock; slower speed grade figures are used so
// that either grade of memory is met.
package asc_pkg;

   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 32768;
   localparam int CNT_W = 4;

   localparam int CLK_PERIOD_NS = 100;

   // memory timing figures in ns
   localparam int READ_CYCLE_MIN_NS = 100;
   localparam int ADDRESS_ACCESS_MAX_NS = 100;
   localparam int GATE_ACCESS_MAX_NS = 50;
   localparam int RELEASE_MAX_NS = 35;
   localparam int WRITE_PULSE_MIN_NS = 70;
   localparam int WRITE_CYCLE_MIN_NS = 100;
   localparam int ADDR_SETUP_MIN_NS = 0;
   localparam int ADDR_TO_END_MIN_NS = 80;
   localparam int SELECT_TO_END_MIN_NS = 80;
   localparam int DATA_SETUP_MIN_NS = 35;
   localparam int DATA_HOLD_MIN_NS = 0;
   localparam int POWERDOWN_RECOVERY_MIN_NS = READ_CYCLE_MIN_NS;

   function automatic int ceil_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   // one spare cycle so that data are sampled with margin past access
   localparam int SAMPLE_MARGIN_CYC = 1;
   localparam int READ_HOLD_CYC = max2(
      max2(ceil_cyc(ADDRESS_ACCESS_MAX_NS), ceil_cyc(GATE_ACCESS_MAX_NS)),
      ceil_cyc(READ_CYCLE_MIN_NS)) + SAMPLE_MARGIN_CYC;
   localparam int TURN_CYC = ceil_cyc(RELEASE_MAX_NS);
   localparam int WRITE_PULSE_CYC = max2(ceil_cyc(WRITE_PULSE_MIN_NS),
      ceil_cyc(DATA_SETUP_MIN_NS));
   localparam int RECOVERY_CYC = ceil_cyc(POWERDOWN_RECOVERY_MIN_NS);

   localparam logic [CNT_W-1:0] READ_LOAD = CNT_W'(READ_HOLD_CYC - 1);
   localparam logic [CNT_W-1:0] TURN_LOAD = CNT_W'(TURN_CYC - 1);
   localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(WRITE_PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] RECOV_LOAD = CNT_W'(RECOVERY_CYC - 1);

   localparam logic [ADDR_W-1:0] ADDR_RST = '0;
   localparam logic [DATA_W-1:0] DATA_RST = '0;

   typedef enum logic [3:0] {
      ASC_RECOV,
      ASC_IDLE,
      ASC_RD_WAIT,
      ASC_WR_SETUP,
      ASC_WR_PULSE,
      ASC_WR_END,
      ASC_TURN,
      ASC_PWRDN
   } asc_state_e;

endpackage

/* File: rtl/asc_timer.sv */
// asc_timer: small down counter timing the memory cycle phases.
// assumes load and ce come from the controller's clock domain.
`timescale 1ns/1ps
`default_nettype none
module asc_timer (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   ce,
   input  wire logic                   load,
   input  wire logic [asc_pkg::CNT_W-1:0] load_val,
   output logic                        done
);
   import asc_pkg::*;

   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (ce) begin
         if (load) begin
            cnt_q <= load_val;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
         end
      end
   end

   assign done = (cnt_q == '0);
endmodule
`default_nettype wire

/* File: verif/asc_ctrl_asserts.sv */
// asc_ctrl_asserts: pin-timing checks on the memory side of asc_ctrl.
// assumes one clock domain; bound to every asc_ctrl instance below.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_asserts (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       pd_ack,
   input  wire logic [asc_pkg::ADDR_W-1:0] sram_addr,
   input  wire logic                       sram_cs_n,
   input  wire logic                       sram_we_n,
   input  wire logic                       sram_oe_n,
   input  wire logic [asc_pkg::DATA_W-1:0] sram_dq_o,
   input  wire logic                       sram_dq_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_no_bus_clash: assert property (
      sram_dq_oe |-> sram_oe_n && $past(sram_oe_n)) else $error("bus clash");
   a_write_overlap: assert property (
      !sram_we_n |-> !sram_cs_n && sram_oe_n && $past(!sram_cs_n))
      else $error("strobe outside select");
   a_select_before_end: assert property (
      $rose(sram_we_n) |-> sram_cs_n && $past(!sram_cs_n, 2))
      else $error("select too short");
   a_addr_hold: assert property (
      (!sram_we_n || $rose(sram_we_n)) |-> $stable(sram_addr))
      else $error("address moved in write");
   a_data_hold: assert property (
      (!sram_we_n || $rose(sram_we_n)) |-> sram_dq_oe && $stable(sram_dq_o))
      else $error("write data moved");
   a_read_hold: assert property (
      $fell(sram_oe_n) |-> sram_we_n && !sram_cs_n
         ##1 !sram_oe_n && $stable(sram_addr)) else $error("read too short");
   a_cycle_gap: assert property (
      $rose(sram_cs_n) |=> sram_cs_n) else $error("cycles too close");
   a_pd_deselect: assert property (
      pd_ack |-> sram_cs_n && sram_we_n) else $error("selected in power-down");
   a_pd_recover: assert property (
      $fell(pd_ack) |-> sram_cs_n ##1 sram_cs_n) else $error("no recovery");
endmodule
bind asc_ctrl asc_ctrl_asserts u_chk (
   .clk(clk), .rst_n(rst_n), .pd_ack(pd_ack), .sram_addr(sram_addr),
   .sram_cs_n(sram_cs_n), .sram_we_n(sram_we_n), .sram_oe_n(sram_oe_n),
   .sram_dq_o(sram_dq_o), .sram_dq_oe(sram_dq_oe));
`default_nettype wire

/* File: verif/asc_sram_model.sv */
// asc_sram_model: behavioural 32768 x 8 asynchronous static memory.
// assumes split controller pins; the shared bus is resolved here.
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model (
   input  wire logic        slow,
   input  wire logic [14:0] addr,
   input  wire logic        cs_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic [7:0]  dq_o,
   input  wire logic        dq_oe,
   output logic      [7:0]  dq_i
);
   logic [7:0] mem [0:32767];
   logic [7:0] dout;
   logic [7:0] flt;
   logic       drv;
   logic       wr_on = 1'b0;
   wire        rd = !cs_n && we_n && !oe_n;
   wire        wr = !cs_n && !we_n;
   initial begin
      foreach (mem[i]) mem[i] = 8'(i) ^ 8'h3c;
      dout = 8'h00;
      flt = 8'h5a;
      drv = 1'b0;
   end
   // a floating bus wanders so a stale value never passes for data
   always #50 flt = ~flt;
   always @(addr or rd) begin
      dout <= #20 ~mem[addr];
      dout <= #(slow ? 100 : 85) mem[addr];
      drv <= #(rd ? 10 : (slow ? 35 : 30)) rd;
   end
   // first rising of strobe or select ends the overlap and stores
   always @(wr) begin
      if (wr_on && !wr) mem[addr] = dq_i;
      wr_on = wr;
   end
   always_comb begin
      if (dq_oe && drv) dq_i = 8'hxx;
      else if (dq_oe) dq_i = dq_o;
      else if (drv) dq_i = dout;
      else dq_i = flt;
   end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// tb: self-checking bench for asc_ctrl against a behavioural memory.
// assumes asc_pkg is compiled first; the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import asc_pkg::*;
   logic              clk, rst_n, ce, req_valid, req_write, pd_req, slow;
   logic              req_ready, resp_valid, pd_ack, cs_n, we_n, oe_n, dq_oe;
   logic              ce_rnd;
   logic [ADDR_W-1:0] req_addr, addr, a;
   logic [DATA_W-1:0] req_wdata, resp_rdata, dq_o, dq_i;
   logic [DATA_W-1:0] shadow [0:MEM_DEPTH-1];
   int                n_fail = 0, checked = 0, seed = 32'h1492;
   asc_ctrl DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .resp_valid(resp_valid),
      .resp_rdata(resp_rdata), .pd_req(pd_req), .pd_ack(pd_ack),
      .sram_addr(addr), .sram_cs_n(cs_n), .sram_we_n(we_n),
      .sram_oe_n(oe_n), .sram_dq_o(dq_o), .sram_dq_oe(dq_oe),
      .sram_dq_i(dq_i));
   asc_sram_model u_mem (.slow(slow), .addr(addr), .cs_n(cs_n),
      .we_n(we_n), .oe_n(oe_n), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) ce <= ce_rnd ? (($random(seed) & 3) != 0) : 1'b1;
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] ad,
                       input logic [DATA_W-1:0] d);
      int n;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= ad;
      req_wdata <= d;
      n = 0;
      do begin @(negedge clk); n++; end while (!(req_ready === 1'b1 && ce) && n < 60);
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      do begin @(negedge clk); n++; end while (resp_valid !== 1'b1 && n < 60);
      chk("resp_valid", 8'h01, {7'h00, resp_valid});
      if (w) shadow[ad] = d;
      else chk("read data", shadow[ad], resp_rdata);
      @(posedge clk);
   endtask
   task automatic report_and_stop();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // about 800 cycles of traffic expected; twenty times that is a hang
   initial begin
      #1_600_000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0; ce_rnd = 1'b0; req_valid = 1'b0;
      req_write = 1'b0; req_addr = '0; req_wdata = '0; pd_req = 1'b0;
      slow = 1'b0;
      foreach (shadow[i]) shadow[i] = 8'(i) ^ 8'h3c;
      repeat (5) @(posedge clk);
      chk("idle pins", 8'h07, {5'h00, cs_n, we_n, oe_n});
      chk("bus drive", 8'h00, {7'h00, dq_oe});
      chk("ready in reset", 8'h00, {7'h00, req_ready});
      rst_n <= 1'b1;
      xfer(1'b1, 15'h7fff, 8'ha5);
      xfer(1'b1, 15'h0000, 8'h5a);
      xfer(1'b0, 15'h7fff, 8'h00);
      xfer(1'b0, 15'h0000, 8'h00);
      ce_rnd <= 1'b1;
      repeat (80) begin
         slow <= $random(seed);
         a = ($random(seed) & 1) ? ADDR_W'($random(seed)) : ADDR_W'($random(seed) & 15);
         xfer($random(seed), a, DATA_W'($random(seed)));
      end
      pd_req <= 1'b1;
      repeat (20) @(negedge clk);
      chk("pd_ack", 8'h01, {7'h00, pd_ack});
      chk("pd select", 8'h01, {7'h00, cs_n});
      @(posedge clk);
      pd_req <= 1'b0;
      xfer(1'b0, 15'h7fff, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
